// >>> i2c_host_model.sv
`timescale 1ns/100ps
module i2c_host_model
  import supply_gap_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // Five system clocks per serial phase keeps above the four the port needs.
  task automatic half();
    repeat (5) @(negedge clk_sys_in);
  endtask

  // Data moves two clocks after the clock fall so the port never sees both change together.
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = ~b;
    half();
    scl_out = 1'b1;
    half();
    r = sda_in;
    scl_out = 1'b0;
    repeat (2) @(negedge clk_sys_in);
  endtask

  task automatic start();
    sda_low_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b0;
    repeat (2) @(negedge clk_sys_in);
  endtask

  task automatic stop();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b0;
    half();
  endtask

  task automatic put_byte(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ok = ok & ~r;
  endtask

  task automatic write_reg(input logic [7:0] p, input logic [7:0] v, output logic ok);
    ok = 1'b1;
    start();
    put_byte({DEVICE_ADDR_DEFAULT, 1'b0}, ok);
    put_byte(p, ok);
    put_byte(v, ok);
    stop();
  endtask

  task automatic read_reg(input logic [7:0] p, output logic [7:0] v, output logic ok);
    logic r;
    ok = 1'b1;
    start();
    put_byte({DEVICE_ADDR_DEFAULT, 1'b0}, ok);
    put_byte(p, ok);
    stop();
    start();
    put_byte({DEVICE_ADDR_DEFAULT, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v[i]);
    end
    bit_io(1'b1, r);
    stop();
  endtask
endmodule // i2c_host_model

// >>> serial_reg_port.sv
`timescale 1ns/100ps
module serial_reg_port
  import supply_gap_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [6:0] dev_addr_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  input wire logic [7:0] rd_data_in,
  output logic [7:0] ptr_out,
  output logic wr_en_out,
  output logic [7:0] wr_data_out
);
  import supply_gap_pkg::*;

  link_state_t state_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic rw_r;
  logic first_r;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise = scl_in & ~scl_q_r;
  assign scl_fall = ~scl_in & scl_q_r;
  assign start_cond = scl_in & scl_q_r & sda_q_r & ~sda_in;
  assign stop_cond = scl_in & scl_q_r & ~sda_q_r & sda_in;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_r <= LS_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      sda_oe_out <= 1'b0;
      ptr_out <= 8'h00;
      wr_en_out <= 1'b0;
      wr_data_out <= 8'h00;
    end else begin
      wr_en_out <= 1'b0;
      if (start_cond) begin
        state_r <= LS_ADDR;
        bit_cnt_r <= 4'h0;
        first_r <= 1'b1;
        sda_oe_out <= 1'b0;
      end else if (stop_cond) begin
        state_r <= LS_IDLE;
        sda_oe_out <= 1'b0;
      end else begin
        case (state_r)
          LS_ADDR, LS_WR: begin
            if (scl_rise && bit_cnt_r != 4'h8) begin
              shift_r <= {shift_r[6:0], sda_in};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              if (state_r == LS_ADDR) begin
                if (shift_r[7:1] == dev_addr_in) begin
                  rw_r <= shift_r[0];
                  sda_oe_out <= 1'b1;
                  state_r <= LS_ADDR_ACK;
                end else begin
                  state_r <= LS_IDLE;
                end
              end else begin
                // The first written byte only sets the register pointer.
                if (first_r) begin
                  ptr_out <= shift_r;
                end else begin
                  wr_en_out <= 1'b1;
                  wr_data_out <= shift_r;
                end
                first_r <= 1'b0;
                sda_oe_out <= 1'b1;
                state_r <= LS_WR_ACK;
              end
            end
          end
          LS_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (rw_r) begin
                shift_r <= rd_data_in;
                sda_oe_out <= ~rd_data_in[7];
                state_r <= LS_RD;
              end else begin
                sda_oe_out <= 1'b0;
                state_r <= LS_WR;
              end
            end
          end
          LS_WR_ACK: begin
            if (scl_fall) begin
              if (!first_r && wr_en_out == 1'b0) begin
                ptr_out <= ptr_out;
              end
              sda_oe_out <= 1'b0;
              bit_cnt_r <= 4'h0;
              state_r <= LS_WR;
            end
          end
          LS_RD: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h7) begin
                sda_oe_out <= 1'b0;
                state_r <= LS_RD_ACK;
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                sda_oe_out <= ~shift_r[6];
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          LS_RD_ACK: begin
            // The pointer advances on the master's acknowledge so the next byte is ready at the fall.
            if (scl_rise) begin
              if (sda_in) begin
                state_r <= LS_IDLE;
              end else begin
                ptr_out <= ptr_out + 8'h01;
              end
            end else if (scl_fall) begin
              shift_r <= rd_data_in;
              sda_oe_out <= ~rd_data_in[7];
              bit_cnt_r <= 4'h0;
              state_r <= LS_RD;
            end
          end
          default: begin
            sda_oe_out <= 1'b0;
          end
        endcase
        if (wr_en_out) begin
          ptr_out <= ptr_out + 8'h01;
        end
      end
    end
  end
endmodule // serial_reg_port

// >>> supply_gap_monitor.sv
`timescale 1ns/100ps
module supply_gap_monitor
  import supply_gap_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = supply_gap_pkg::DEVICE_ADDR_DEFAULT
)
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [12:0] supply_mv_in,
  output logic battery_backup_out,
  output logic battery_connect_out,
  output logic charge_enable_out,
  output logic monitor_active_out,
  output logic [12:0] trip_mv_out
);
  import supply_gap_pkg::*;

  logic [7:0] gap_filter_time_r;
  logic [7:0] trip_threshold_select_r;
  logic [7:0] max_drop_after_trip_r;
  logic [7:0] ptr;
  logic [7:0] wr_data;
  logic wr_en;
  logic [7:0] rd_data;
  monitor_state_t state_r;
  monitor_state_t state_nxt;
  logic [8:0] unit_cnt_r;
  logic [8:0] gap_units_r;
  logic unit_tick;
  logic [15:0] trip_level;
  logic [15:0] supply_wide;
  logic below_trip;
  logic drop_hit;
  logic time_hit;

  function automatic logic [15:0] trip_level_mv(input logic [7:0] sel);
    case (sel)
      SEL_LEVEL_1: trip_level_mv = TRIP_MV_1;
      SEL_LEVEL_2: trip_level_mv = TRIP_MV_2;
      SEL_LEVEL_3: trip_level_mv = TRIP_MV_3;
      SEL_LEVEL_4: trip_level_mv = TRIP_MV_4;
      default: trip_level_mv = 16'h0000;
    endcase
  endfunction

  serial_reg_port u_port (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .dev_addr_in(DEVICE_ADDR),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_out(sda_oe_out),
    .rd_data_in(rd_data),
    .ptr_out(ptr),
    .wr_en_out(wr_en),
    .wr_data_out(wr_data)
  );

  // The pin is open drain: the driven level is always low.
  always_ff @(posedge clk_sys_in) begin
    sda_out <= 1'b0;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      gap_filter_time_r <= GAP_FILTER_TIME_RST;
      trip_threshold_select_r <= TRIP_THRESHOLD_SELECT_RST;
      max_drop_after_trip_r <= MAX_DROP_AFTER_TRIP_RST;
    end else if (wr_en) begin
      case (ptr)
        GAP_FILTER_TIME_OFS: gap_filter_time_r <= wr_data;
        TRIP_THRESHOLD_SELECT_OFS: trip_threshold_select_r <= wr_data;
        // Values outside one to nine are stored as written; the host keeps the range.
        MAX_DROP_AFTER_TRIP_OFS: max_drop_after_trip_r <= wr_data;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (ptr)
      GAP_FILTER_TIME_OFS: rd_data = gap_filter_time_r;
      TRIP_THRESHOLD_SELECT_OFS: rd_data = trip_threshold_select_r;
      MAX_DROP_AFTER_TRIP_OFS: rd_data = max_drop_after_trip_r;
      TRIP_MV_LOW_OFS: rd_data = trip_mv_out[7:0];
      TRIP_MV_HIGH_OFS: rd_data = {3'h0, trip_mv_out[12:8]};
      MONITOR_STATUS_OFS: rd_data = {4'h0, state_r};
      default: rd_data = 8'h00;
    endcase
  end

  assign trip_level = trip_level_mv(trip_threshold_select_r);
  assign supply_wide = {3'h0, supply_mv_in};
  assign below_trip = supply_wide < trip_level;
  // A drop strictly larger than the allowed amount engages the battery.
  assign drop_hit = (supply_wide + (16'(max_drop_after_trip_r) * DROP_MV_PER_COUNT)) < trip_level;
  assign time_hit = gap_units_r >= {1'b0, gap_filter_time_r};
  assign unit_tick = unit_cnt_r == 9'(GAP_UNIT_CYCLES - 1);

  // The time base restarts with each gap so the window is not shortened by a stale phase.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || state_r != ST_WATCH) begin
      unit_cnt_r <= 9'h000;
      gap_units_r <= 9'h000;
    end else if (unit_tick) begin
      unit_cnt_r <= 9'h000;
      if (gap_units_r != 9'h1FF) begin
        gap_units_r <= gap_units_r + 9'h001;
      end
    end else begin
      unit_cnt_r <= unit_cnt_r + 9'h001;
    end
  end

  always_comb begin
    state_nxt = state_r;
    if (trip_threshold_select_r == SEL_DISABLED) begin
      state_nxt = ST_OFF;
    end else begin
      case (state_r)
        ST_OFF: state_nxt = ST_IDLE;
        ST_IDLE: begin
          if (below_trip) begin
            state_nxt = ST_WATCH;
          end
        end
        ST_WATCH: begin
          if (!below_trip) begin
            state_nxt = ST_IDLE;
          end else if (time_hit || drop_hit) begin
            state_nxt = ST_BACKUP;
          end
        end
        ST_BACKUP: begin
          if (!below_trip) begin
            state_nxt = ST_IDLE;
          end
        end
        default: state_nxt = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      trip_mv_out <= 13'h0000;
    end else if (state_r == ST_IDLE && state_nxt == ST_WATCH) begin
      trip_mv_out <= supply_mv_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      battery_backup_out <= 1'b0;
      battery_connect_out <= 1'b0;
      charge_enable_out <= 1'b0;
      monitor_active_out <= 1'b0;
    end else begin
      battery_backup_out <= state_nxt == ST_BACKUP;
      battery_connect_out <= state_nxt != ST_OFF;
      charge_enable_out <= state_nxt != ST_OFF && state_nxt != ST_BACKUP;
      monitor_active_out <= state_nxt != ST_OFF;
    end
  end

  filter_reset_a: assert property (@(posedge clk_sys_in) reset_in |=> gap_filter_time_r == GAP_FILTER_TIME_RST)
    else $error("gap filter time not at reset value");
  drop_reset_a: assert property (@(posedge clk_sys_in) reset_in |=> max_drop_after_trip_r == MAX_DROP_AFTER_TRIP_RST)
    else $error("max drop not at reset value");
  disabled_off_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    trip_threshold_select_r == SEL_DISABLED |=> !battery_backup_out && !monitor_active_out)
    else $error("backup active while monitoring disabled");
  battery_isolated_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    trip_threshold_select_r == SEL_DISABLED |=> !battery_connect_out && !charge_enable_out)
    else $error("battery touched while monitoring disabled");
  short_gap_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    state_r == ST_WATCH && !time_hit && !drop_hit |=> !battery_backup_out)
    else $error("backup engaged before filter time");
  fire_only_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    state_r == ST_IDLE ##1 state_r == ST_WATCH |-> !battery_backup_out)
    else $error("comparator firing engaged backup directly");
  capture_trip_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    state_r == ST_IDLE && below_trip && trip_threshold_select_r != SEL_DISABLED |=> trip_mv_out == $past(supply_mv_in))
    else $error("trip voltage not captured");
  timeout_engage_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    state_r == ST_WATCH && below_trip && gap_units_r >= {1'b0, gap_filter_time_r}
    && trip_threshold_select_r != SEL_DISABLED |=> battery_backup_out)
    else $error("backup not engaged after filter time");
  drop_engage_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    state_r == ST_WATCH && drop_hit && trip_threshold_select_r != SEL_DISABLED |=> battery_backup_out)
    else $error("backup not engaged on excess drop");
  recover_gap_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    state_r == ST_WATCH && !below_trip && trip_threshold_select_r != SEL_DISABLED
    |=> state_r == ST_IDLE && !battery_backup_out)
    else $error("recovery did not abandon gap evaluation");
  unit_period_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    state_r == ST_WATCH && gap_units_r == 9'h000 && unit_cnt_r == 9'h000 && state_nxt == ST_WATCH
    |=> gap_units_r == 9'h000)
    else $error("filter unit counted too early");
endmodule // supply_gap_monitor

// >>> supply_gap_pkg.sv
package supply_gap_pkg;
  // Register map, byte offsets on the serial link.
  localparam logic [7:0] GAP_FILTER_TIME_OFS = 8'h1A;
  localparam logic [7:0] TRIP_THRESHOLD_SELECT_OFS = 8'h1B;
  localparam logic [7:0] MAX_DROP_AFTER_TRIP_OFS = 8'h1C;
  localparam logic [7:0] TRIP_MV_LOW_OFS = 8'h1D;
  localparam logic [7:0] TRIP_MV_HIGH_OFS = 8'h1E;
  localparam logic [7:0] MONITOR_STATUS_OFS = 8'h1F;

  // Reset values and the default device address.
  localparam logic [7:0] GAP_FILTER_TIME_RST = 8'h19;
  localparam logic [7:0] TRIP_THRESHOLD_SELECT_RST = 8'h02;
  localparam logic [7:0] MAX_DROP_AFTER_TRIP_RST = 8'h03;
  localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h6B;

  // Threshold select codes and their trip levels in millivolts.
  localparam logic [7:0] SEL_DISABLED = 8'h00;
  localparam logic [7:0] SEL_LEVEL_1 = 8'h01;
  localparam logic [7:0] SEL_LEVEL_2 = 8'h02;
  localparam logic [7:0] SEL_LEVEL_3 = 8'h03;
  localparam logic [7:0] SEL_LEVEL_4 = 8'h04;
  localparam logic [15:0] TRIP_MV_1 = 16'h1336;
  localparam logic [15:0] TRIP_MV_2 = 16'h1225;
  localparam logic [15:0] TRIP_MV_3 = 16'h1114;
  localparam logic [15:0] TRIP_MV_4 = 16'h1000;
  localparam logic [15:0] DROP_MV_PER_COUNT = 16'h0064;

  // Gap filter time base.
  localparam int CLK_MHZ = 25;
  localparam int GAP_UNIT_US = 10;
  localparam int GAP_UNIT_CYCLES = GAP_UNIT_US * CLK_MHZ;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_IDLE = 4'h2,
    ST_WATCH = 4'h4,
    ST_BACKUP = 4'h8
  } monitor_state_t;

  typedef enum logic [6:0] {
    LS_IDLE = 7'h01,
    LS_ADDR = 7'h02,
    LS_ADDR_ACK = 7'h04,
    LS_WR = 7'h08,
    LS_WR_ACK = 7'h10,
    LS_RD = 7'h20,
    LS_RD_ACK = 7'h40
  } link_state_t;
endpackage

// >>> test_supply_gap_monitor.sv
`timescale 1ns/100ps
module test_supply_gap_monitor;
  import supply_gap_pkg::*;
  logic clk_sys_in, reset_in, scl, host_low, sda_out, sda_oe, sda_line;
  logic backup, connect, charge, active, ok;
  logic [12:0] supply, trip_mv, lvl, prev;
  logic [7:0] rd, f, d;
  int n_mismatch = 0;
  int checks = 0;
  int seed = 32'h2865;

  // Open drain with a pull-up: low if either party pulls.
  assign sda_line = ~(sda_oe & ~sda_out) & ~host_low;

  supply_gap_monitor dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe), .supply_mv_in(supply), .battery_backup_out(backup),
    .battery_connect_out(connect), .charge_enable_out(charge), .monitor_active_out(active), .trip_mv_out(trip_mv));
  i2c_host_model host (.clk_sys_in(clk_sys_in), .sda_in(sda_line), .scl_out(scl), .sda_low_out(host_low));

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  function automatic logic [12:0] level(input int c);
    case (c)
      1: return TRIP_MV_1[12:0];
      2: return TRIP_MV_2[12:0];
      3: return TRIP_MV_3[12:0];
      default: return TRIP_MV_4[12:0];
    endcase
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    host.write_reg(p, v, ok);
    check("write ack", {15'h0000, ok}, 16'h0001);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] p, input logic [7:0] exp);
    host.read_reg(p, rd, ok);
    check(what, {7'h00, ok, rd}, {8'h01, exp});
  endtask

  task automatic stop_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_sys_in);
    n_mismatch++;
    stop_test();
  end

  initial begin
    reset_in = 1'b1;
    supply = 13'h1388;
    tick(3);
    reset_in = 1'b0;
    tick(2);
    rd_chk("filter reset", GAP_FILTER_TIME_OFS, 8'h19);
    rd_chk("drop reset", MAX_DROP_AFTER_TRIP_OFS, 8'h03);
    rd_chk("select reset", TRIP_THRESHOLD_SELECT_OFS, TRIP_THRESHOLD_SELECT_RST);
    rd_chk("unmapped", 8'h30, 8'h00);
    f = 8'($random(seed));
    wr(GAP_FILTER_TIME_OFS, f);
    rd_chk("filter rw", GAP_FILTER_TIME_OFS, f);
    $display("test registers done");
    wr(GAP_FILTER_TIME_OFS, 8'hFF);
    wr(MAX_DROP_AFTER_TRIP_OFS, 8'h09);
    prev = trip_mv;
    for (int c = 1; c < 5; c++) begin
      wr(TRIP_THRESHOLD_SELECT_OFS, 8'(c));
      lvl = level(c);
      supply = lvl;
      tick(5);
      check("no trip at level", trip_mv, prev);
      supply = lvl - 13'h0001;
      tick(3);
      check("captured", trip_mv, lvl - 13'h0001);
      rd_chk("watching", MONITOR_STATUS_OFS, 8'h04);
      check("fire only", backup, 1'b0);
      supply = lvl;
      tick(3);
      rd_chk("recovered", MONITOR_STATUS_OFS, 8'h02);
      check("no backup", backup, 1'b0);
      prev = lvl - 13'h0001;
    end
    rd_chk("trip low", TRIP_MV_LOW_OFS, prev[7:0]);
    rd_chk("trip high", TRIP_MV_HIGH_OFS, {3'h0, prev[12:8]});
    $display("test levels done");
    // The supply must sit above every level before the select changes, or the gap starts inside the write.
    supply = 13'h1388;
    f = 8'h01 + 8'($unsigned($random(seed)) % 4);
    wr(GAP_FILTER_TIME_OFS, f);
    wr(TRIP_THRESHOLD_SELECT_OFS, SEL_LEVEL_2);
    lvl = level(2);
    supply = lvl - 13'h0010;
    tick(int'(f) * GAP_UNIT_CYCLES - 20);
    check("short gap", backup, 1'b0);
    supply = 13'h1388;
    tick(3);
    rd_chk("gap dropped", MONITOR_STATUS_OFS, 8'h02);
    tick(5);
    supply = lvl - 13'h0010;
    tick(int'(f) * GAP_UNIT_CYCLES - 5);
    check("before filter", backup, 1'b0);
    tick(10);
    check("after filter", backup, 1'b1);
    check("no charge on backup", charge, 1'b0);
    supply = 13'h1388;
    tick(3);
    check("back on supply", backup, 1'b0);
    $display("test filter done");
    d = 8'h01 + 8'($unsigned($random(seed)) % 9);
    wr(MAX_DROP_AFTER_TRIP_OFS, d);
    wr(GAP_FILTER_TIME_OFS, 8'hFF);
    supply = lvl - 13'(d) * 13'h0064;
    tick(10);
    check("drop at limit", backup, 1'b0);
    supply = supply - 13'h0001;
    tick(3);
    check("drop beyond", backup, 1'b1);
    rd_chk("backup status", MONITOR_STATUS_OFS, 8'h08);
    supply = 13'h1388;
    tick(3);
    $display("test drop done");
    wr(TRIP_THRESHOLD_SELECT_OFS, SEL_DISABLED);
    tick(3);
    check("monitor off", active, 1'b0);
    check("battery off", connect, 1'b0);
    check("charge off", charge, 1'b0);
    supply = 13'h0000;
    tick(300);
    check("no backup off", backup, 1'b0);
    rd_chk("serial alive", TRIP_THRESHOLD_SELECT_OFS, 8'h00);
    supply = 13'h1388;
    wr(TRIP_THRESHOLD_SELECT_OFS, SEL_LEVEL_3);
    tick(3);
    check("battery on", connect, 1'b1);
    check("charge on", charge, 1'b1);
    check("monitor on", active, 1'b1);
    $display("test disable done");
    stop_test();
  end
endmodule // test_supply_gap_monitor
